// ===== rtl/cobk_top.sv
// charger option control bank: two byte registers and their control logic
`timescale 1ns/100ps
`default_nettype none
module cobk_top
   import cobk_pkg::*;
#(
   parameter logic [cobk_pkg::COBK_SHIP_W-1:0] SHIP_CYCLES   = cobk_pkg::COBK_SHIP_CYC,
   parameter logic [cobk_pkg::COBK_WAKE_W-1:0] WAKE_CYCLES   = cobk_pkg::COBK_WAKE_CYC,
   parameter logic [cobk_pkg::COBK_DEG_W-1:0]  DEG_MS_CYCLES = cobk_pkg::COBK_DEG_MS_CYC,
   parameter logic [cobk_pkg::COBK_DEG_W-1:0]  DEG_S_CYCLES  = cobk_pkg::COBK_DEG_S_CYC
) (
   input  wire logic                         core_clk_i,
   input  wire logic                         rstn_i,
   input  wire logic [cobk_pkg::COBK_AW-1:0] reg_addr_i,
   input  wire logic                         reg_wr_i,
   input  wire logic [cobk_pkg::COBK_DW-1:0] reg_wdata_i,
   output logic      [cobk_pkg::COBK_DW-1:0] reg_rdata_o,
   input  wire logic                         low_power_mode_i,
   input  wire logic                         battery_below_min_i,
   input  wire logic                         charger_ok_i,
   input  wire logic                         comparator_input_i,
   input  wire logic                         current_limit_hiz_pin_i,
   output logic                              battery_current_buffer_enable_o,
   output logic                              system_power_sense_enable_o,
   output logic                              low_power_hot_alert_enable_o,
   output logic                              input_sense_resistor_select_o,
   output logic                              charge_sense_resistor_select_o,
   output logic                              system_power_gain_select_o,
   output logic                              comparator_reference_select_o,
   output logic                              comparator_output_o,
   output logic                              converter_disable_o,
   output logic                              charger_ok_output_o,
   output logic                              pass_through_mode_o,
   output logic                              high_impedance_mode_o,
   output logic                              shipping_discharge_o,
   output logic                              wakeup_charge_o
);
   import cobk_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // register storage and decode
   logic [7:0] opt_hi_r;
   logic [7:0] opt_lo_r;
   logic [7:0] opt_lo_nxt;
   logic [7:0] rdata_r;
   wire  logic wr_hi_w   = reg_wr_i && (reg_addr_i == COBK_ADDR_HIGH);
   wire  logic wr_lo_w   = reg_wr_i && (reg_addr_i == COBK_ADDR_LOW);
   wire  logic ship_start_w = wr_lo_w && reg_wdata_i[COBK_L_SHIP];
   wire  logic [7:0] rd_mux_w = (reg_addr_i == COBK_ADDR_HIGH) ? opt_hi_r :
                                (reg_addr_i == COBK_ADDR_LOW)  ? opt_lo_r : COBK_UNMAPPED;

   wire  logic [1:0] hot_sel_w = opt_hi_r[COBK_H_HOT_HI:COBK_H_HOT_LO];
   wire  logic [1:0] deg_sel_w = opt_lo_r[COBK_L_DEG_HI:COBK_L_DEG_LO];
   wire  logic ship_done_w;
   wire  logic wake_clr_w;

   // lower byte: host writes win over the self-clearing bits
   always_comb begin
      opt_lo_nxt = opt_lo_r;
      if (ship_done_w) begin
         opt_lo_nxt[COBK_L_SHIP] = 1'b0;
      end
      if (wake_clr_w) begin
         opt_lo_nxt[COBK_L_WAKE] = 1'b0;
      end
      if (wr_lo_w) begin
         opt_lo_nxt = reg_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         opt_hi_r <= COBK_RESET_HIGH;
         opt_lo_r <= COBK_RESET_LOW;
         rdata_r  <= COBK_UNMAPPED;
      end else begin
         if (wr_hi_w) begin
            opt_hi_r <= reg_wdata_i;
         end
         opt_lo_r <= opt_lo_nxt;
         rdata_r  <= rd_mux_w;   // read data one cycle after the address
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: three flops, accept a level once stages two and three agree
   wire  logic [1:0] pin_raw_w = {current_limit_hiz_pin_i, comparator_input_i};
   logic [1:0] pin_stable_r;
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         logic s1_r;
         logic s2_r;
         logic s3_r;
         always_ff @(posedge core_clk_i or negedge rstn_i) begin
            if (!rstn_i) begin
               s1_r            <= 1'b1;
               s2_r            <= 1'b1;
               s3_r            <= 1'b1;
               pin_stable_r[gi] <= 1'b1;
            end else begin
               s1_r <= pin_raw_w[gi];
               s2_r <= s1_r;
               s3_r <= s2_r;
               if (s2_r == s3_r) begin
                  pin_stable_r[gi] <= s3_r;
               end
            end
         end
      end
   endgenerate
   wire logic cmp_above_w = pin_stable_r[0];
   wire logic limit_low_w = !pin_stable_r[1];

   ////////////////////////////////////////////////////////////////////////////
   // comparator with falling-edge deglitch
   // polarity 0: above drives low; polarity 1: below drives low
   wire  logic cmp_on_w  = (deg_sel_w != COBK_DEG_OFF);
   wire  logic cmp_raw_w = cmp_above_w ~^ opt_lo_r[COBK_L_COMPARATOR_POLARITY_SELECT];
   wire  logic cmp_high_w = !cmp_on_w || cmp_raw_w;
   // deglitch length from the select field
   wire  logic [COBK_DEG_W-1:0] deg_load_w =
      (deg_sel_w == COBK_DEG_MS) ? DEG_MS_CYCLES :
      (deg_sel_w == COBK_DEG_S)  ? DEG_S_CYCLES  : COBK_DEG_US_CYC;
   logic cmp_out_r;
   wire  logic deg_busy_w;
   wire  logic deg_done_w;
   wire  logic deg_start_w = !cmp_high_w && cmp_out_r && !deg_busy_w && !deg_done_w;

   cobk_timer #(.W(COBK_DEG_W)) u_deg_timer (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .start_i    (deg_start_w),
      .stop_i     (cmp_high_w),
      .load_i     (deg_load_w),
      .busy_o     (deg_busy_w),
      .done_o     (deg_done_w)
   );

   // rise immediately, fall only after the deglitch expires
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cmp_out_r <= 1'b1;
      end else if (cmp_high_w) begin
         cmp_out_r <= 1'b1;
      end else if (deg_done_w) begin
         cmp_out_r <= 1'b0;
      end
   end

   // power path cutoff latches until the host clears the enable bit
   logic cutoff_r;
   wire  logic cutoff_set_w = opt_lo_r[COBK_L_CUTOFF] && !cmp_out_r;
   // latch cutoff on trip, trip wins over clear
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cutoff_r <= 1'b0;
      end else if (cutoff_set_w) begin
         cutoff_r <= 1'b1;
      end else if (!opt_lo_r[COBK_L_CUTOFF]) begin
         cutoff_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shipping discharge interval
   // restart on every write of a one
   cobk_timer #(.W(COBK_SHIP_W)) u_ship_timer (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .start_i    (ship_start_w),
      .stop_i     (!opt_lo_r[COBK_L_SHIP]),
      .load_i     (SHIP_CYCLES),
      .busy_o     (),
      .done_o     (ship_done_w)
   );

   ////////////////////////////////////////////////////////////////////////////
   // auto wakeup charge sequencing
   cobk_wake_t wk_state_r;
   cobk_wake_t wk_state_nxt;
   wire  logic wake_en_w   = opt_lo_r[COBK_L_WAKE];
   wire  logic wk_arm_w    = (wk_state_r == COBK_WK_IDLE) && wake_en_w && battery_below_min_i;
   wire  logic wk_done_w;
   assign wake_clr_w = (wk_state_r == COBK_WK_CHARGE) && !battery_below_min_i;

   // wakeup interval restarts with each arming
   cobk_timer #(.W(COBK_WAKE_W)) u_wake_timer (
      .core_clk_i (core_clk_i),
      .rstn_i     (rstn_i),
      .start_i    (wk_arm_w),
      .stop_i     (wk_state_r != COBK_WK_CHARGE),
      .load_i     (WAKE_CYCLES),
      .busy_o     (),
      .done_o     (wk_done_w)
   );

   // charge while below minimum, at most the interval
   always_comb begin
      wk_state_nxt = wk_state_r;
      unique case (wk_state_r)
         COBK_WK_IDLE: begin
            if (wk_arm_w) begin
               wk_state_nxt = COBK_WK_CHARGE;
            end
         end
         COBK_WK_CHARGE: begin
            if (!battery_below_min_i || !wake_en_w) begin
               wk_state_nxt = COBK_WK_IDLE;
            end else if (wk_done_w) begin
               wk_state_nxt = COBK_WK_EXPIRED;
            end
         end
         COBK_WK_EXPIRED: begin
            if (!battery_below_min_i || wr_lo_w) begin
               wk_state_nxt = COBK_WK_IDLE;   // a host write re-arms
            end
         end
         default: begin
            wk_state_nxt = COBK_WK_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wk_state_r <= COBK_WK_IDLE;
      end else begin
         wk_state_r <= wk_state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs; one cycle of lag is harmless next to analog settling
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         battery_current_buffer_enable_o <= 1'b0;
         system_power_sense_enable_o     <= 1'b0;
         low_power_hot_alert_enable_o    <= 1'b0;
         input_sense_resistor_select_o   <= 1'b0;
         charge_sense_resistor_select_o  <= 1'b0;
         system_power_gain_select_o      <= 1'b1;
         comparator_reference_select_o   <= 1'b0;
         converter_disable_o             <= 1'b0;
         charger_ok_output_o             <= 1'b0;
         pass_through_mode_o             <= 1'b0;
         high_impedance_mode_o           <= 1'b0;
      end else begin
         // buffer enable gated by low-power mode
         battery_current_buffer_enable_o <= opt_hi_r[COBK_H_BATTERY_CURRENT_MONITOR_EN] && !low_power_mode_i;
         system_power_sense_enable_o     <= opt_hi_r[COBK_H_SYSTEM_POWER_MONITOR_EN] && !low_power_mode_i;
         // reserved codes leave the alert off
         low_power_hot_alert_enable_o    <= (hot_sel_w == COBK_HOT_SYSTEM_VOLTAGE);
         input_sense_resistor_select_o   <= opt_hi_r[COBK_H_IN_RSNS];
         charge_sense_resistor_select_o  <= opt_hi_r[COBK_H_CHG_RSNS];
         system_power_gain_select_o      <= opt_hi_r[COBK_H_SYSTEM_POWER_MONITOR_GAIN];
         comparator_reference_select_o   <= opt_lo_r[COBK_L_COMPARATOR_REFERENCE_SELECT];
         // cut switches and drop charger ok
         converter_disable_o             <= cutoff_r;
         charger_ok_output_o             <= charger_ok_i && !cutoff_r;
         // limit pin function and pass-through enable
         pass_through_mode_o   <= opt_lo_r[COBK_L_PTM_EN] ||
                                  (limit_low_w && opt_hi_r[COBK_H_PIN_FUNC]);
         high_impedance_mode_o <= limit_low_w && !opt_hi_r[COBK_H_PIN_FUNC];
      end
   end

   assign reg_rdata_o          = rdata_r;
   assign comparator_output_o  = cmp_out_r;
   assign shipping_discharge_o = opt_lo_r[COBK_L_SHIP];
   assign wakeup_charge_o      = wk_state_r[1];

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic [7:0] low_cnt_r;   // consecutive cycles of a low comparator request
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         low_cnt_r <= '0;
      end else if (cmp_high_w) begin
         low_cnt_r <= '0;
      end else if (low_cnt_r != 8'hFF) begin
         low_cnt_r <= low_cnt_r + 8'h01;
      end
   end

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_wake_arm;
      wk_arm_w;
   endsequence
   sequence s_wake_run;
      wakeup_charge_o && (wk_state_r == COBK_WK_CHARGE);
   endsequence

   property p_battery_current_monitor_on;
      opt_hi_r[COBK_H_BATTERY_CURRENT_MONITOR_EN] && !low_power_mode_i |=> battery_current_buffer_enable_o;
   endproperty
   a_battery_current_monitor_on: assert property (p_battery_current_monitor_on)
      else $error("battery current buffer not enabled");
   property p_battery_current_monitor_lpm;
      low_power_mode_i |=> !battery_current_buffer_enable_o && !system_power_sense_enable_o;
   endproperty
   a_battery_current_monitor_lpm: assert property (p_battery_current_monitor_lpm)
      else $error("buffer on during low power mode");
   property p_hot;
      hot_sel_w != COBK_HOT_SYSTEM_VOLTAGE |=> !low_power_hot_alert_enable_o;
   endproperty
   a_hot: assert property (p_hot)
      else $error("hot alert on for a non-enabling code");
   property p_rise;
      cmp_high_w |=> comparator_output_o;
   endproperty
   a_rise: assert property (p_rise)
      else $error("comparator rise was delayed");
   property p_fall_us;
      $fell(comparator_output_o) && (deg_sel_w == COBK_DEG_US) |-> low_cnt_r >= 8'd40;
   endproperty
   a_fall_us: assert property (p_fall_us)
      else $error("comparator fell before 1 us deglitch");
   property p_cutoff;
      cutoff_set_w |=> ##1 converter_disable_o && !charger_ok_output_o;
   endproperty
   a_cutoff: assert property (p_cutoff)
      else $error("cutoff did not disable converter");
   property p_ship_set;
      ship_start_w |=> shipping_discharge_o [*3];
   endproperty
   a_ship_set: assert property (p_ship_set)
      else $error("shipping discharge did not hold after write");
   property p_ship_clr;
      ship_done_w && !wr_lo_w |=> !shipping_discharge_o;
   endproperty
   a_ship_clr: assert property (p_ship_clr)
      else $error("shipping bit not cleared at interval end");
   property p_wake_start;
      s_wake_arm |=> s_wake_run;
   endproperty
   a_wake_start: assert property (p_wake_start)
      else $error("auto wakeup charge did not start");
   property p_wake_clr;
      wake_clr_w && !wr_lo_w |=> !opt_lo_r[COBK_L_WAKE] && !wakeup_charge_o;
   endproperty
   a_wake_clr: assert property (p_wake_clr)
      else $error("auto wakeup bit not cleared");
endmodule // cobk_top
`default_nettype wire

// ===== rtl/cobk_pkg.sv
// constants for the charger option control bank
package cobk_pkg;
   // register bus widths and byte addresses
   localparam int          COBK_AW          = 8;
   localparam int          COBK_DW          = 8;
   localparam logic [7:0]  COBK_ADDR_LOW    = 8'h30;
   localparam logic [7:0]  COBK_ADDR_HIGH   = 8'h31;
   localparam logic [15:0] COBK_RESET_WORD  = 16'h0211;
   localparam logic [7:0]  COBK_RESET_LOW   = COBK_RESET_WORD[7:0];
   localparam logic [7:0]  COBK_RESET_HIGH  = COBK_RESET_WORD[15:8];
   localparam logic [7:0]  COBK_UNMAPPED    = 8'h00;

   // upper byte field positions
   localparam int COBK_H_BATTERY_CURRENT_MONITOR_EN   = 7;
   localparam int COBK_H_HOT_HI    = 6;
   localparam int COBK_H_HOT_LO    = 5;
   localparam int COBK_H_SYSTEM_POWER_MONITOR_EN   = 4;
   localparam int COBK_H_IN_RSNS   = 3;
   localparam int COBK_H_CHG_RSNS  = 2;
   localparam int COBK_H_SYSTEM_POWER_MONITOR_GAIN = 1;
   localparam int COBK_H_PIN_FUNC  = 0;
   // lower byte field positions
   localparam int COBK_L_COMPARATOR_REFERENCE_SELECT   = 7;
   localparam int COBK_L_COMPARATOR_POLARITY_SELECT   = 6;
   localparam int COBK_L_DEG_HI    = 5;
   localparam int COBK_L_DEG_LO    = 4;
   localparam int COBK_L_CUTOFF    = 3;
   localparam int COBK_L_PTM_EN    = 2;
   localparam int COBK_L_SHIP      = 1;
   localparam int COBK_L_WAKE      = 0;

   // field encodings
   localparam logic [1:0] COBK_HOT_OFF    = 2'b00;
   localparam logic [1:0] COBK_HOT_SYSTEM_VOLTAGE   = 2'b01;
   localparam logic [1:0] COBK_DEG_OFF    = 2'b00;
   localparam logic [1:0] COBK_DEG_US     = 2'b01;
   localparam logic [1:0] COBK_DEG_MS     = 2'b10;
   localparam logic [1:0] COBK_DEG_S      = 2'b11;

   // timing in printed units and derived cycle counts
   localparam longint COBK_CLK_HZ       = 40_000_000;
   localparam longint COBK_DEG_US_TIME  = 1;
   localparam longint COBK_DEG_MS_TIME  = 2;
   localparam longint COBK_DEG_S_TIME   = 5;
   localparam longint COBK_SHIP_MS_TIME = 140;
   localparam longint COBK_WAKE_MIN     = 30;
   localparam int     COBK_DEG_W        = 28;
   localparam int     COBK_SHIP_W       = 23;
   localparam int     COBK_WAKE_W       = 37;
   // least times round up, longest times round down
   localparam logic [COBK_DEG_W-1:0] COBK_DEG_US_CYC =
      COBK_DEG_W'((COBK_DEG_US_TIME * COBK_CLK_HZ + 999_999) / 1_000_000);
   localparam logic [COBK_DEG_W-1:0] COBK_DEG_MS_CYC =
      COBK_DEG_W'((COBK_DEG_MS_TIME * COBK_CLK_HZ + 999) / 1000);
   localparam logic [COBK_DEG_W-1:0] COBK_DEG_S_CYC =
      COBK_DEG_W'(COBK_DEG_S_TIME * COBK_CLK_HZ);
   localparam logic [COBK_SHIP_W-1:0] COBK_SHIP_CYC =
      COBK_SHIP_W'((COBK_SHIP_MS_TIME * COBK_CLK_HZ) / 1000);
   localparam logic [COBK_WAKE_W-1:0] COBK_WAKE_CYC =
      COBK_WAKE_W'(COBK_WAKE_MIN * 60 * COBK_CLK_HZ);

   // auto wakeup charge states
   typedef enum logic [2:0] {
      COBK_WK_IDLE    = 3'b001,
      COBK_WK_CHARGE  = 3'b010,
      COBK_WK_EXPIRED = 3'b100
   } cobk_wake_t;
endpackage : cobk_pkg

// ===== rtl/cobk_timer.sv
// restartable down-counting interval timer with a done pulse
`timescale 1ns/100ps
`default_nettype none
module cobk_timer #(
   parameter int W = 8
) (
   input  wire logic         core_clk_i,
   input  wire logic         rstn_i,
   input  wire logic         start_i,
   input  wire logic         stop_i,
   input  wire logic [W-1:0] load_i,
   output logic              busy_o,
   output logic              done_o
);
   logic [W-1:0] cnt_r;
   logic         busy_r;
   logic         done_r;
   wire  logic   last_w = (cnt_r <= W'(1));

   // start wins over stop so a fresh activation always restarts the count
   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_r  <= '0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
      end else begin
         done_r <= 1'b0;
         if (start_i) begin
            cnt_r  <= load_i;
            busy_r <= 1'b1;
         end else if (stop_i) begin
            busy_r <= 1'b0;
         end else if (busy_r) begin
            if (last_w) begin
               busy_r <= 1'b0;
               done_r <= 1'b1;
            end else begin
               cnt_r <= cnt_r - W'(1);
            end
         end
      end
   end

   assign busy_o = busy_r;
   assign done_o = done_r;
endmodule // cobk_timer
`default_nettype wire

// ===== dv/cobk_host.sv
// host controller model driving the byte register port
`timescale 1ns/100ps
`default_nettype none
module cobk_host (
   input  wire logic       core_clk_i,
   output logic      [7:0] reg_addr_o,
   output logic            reg_wr_o,
   output logic      [7:0] reg_wdata_o,
   input  wire logic [7:0] reg_rdata_i
);
   // idle bus at time zero
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 8'h00;
   end
   // one-cycle strobe; stale data is inverted so nothing leans on it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge core_clk_i);
      reg_wr_o = 1'b0;
      reg_wdata_o = ~d;
   endtask
   // read data is registered, so it is taken one edge after the address
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk_i);
      reg_addr_o = a;
      @(negedge core_clk_i);
      d = reg_rdata_i;
   endtask
endmodule // cobk_host
`default_nettype wire

// ===== dv/tb_charger_option_control_bank.sv
// self-checking bench for the charger option control bank
`timescale 1ns/100ps
`default_nettype none
module tb_charger_option_control_bank;
   import cobk_pkg::*;
   logic        core_clk_i, rstn_i, lpm, below, chg_ok, cmp_in, pin, wr;
   logic [7:0]  addr, wdata, rdata, d;
   logic [13:0] o;
   int          errors, compares, cycles;
   cobk_host host (.core_clk_i(core_clk_i), .reg_addr_o(addr), .reg_wr_o(wr),
      .reg_wdata_o(wdata), .reg_rdata_i(rdata));
   cobk_top #(.SHIP_CYCLES(23'd20), .WAKE_CYCLES(37'd50), .DEG_MS_CYCLES(28'd60),
      .DEG_S_CYCLES(28'd80)) dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .low_power_mode_i(lpm), .battery_below_min_i(below), .charger_ok_i(chg_ok),
      .comparator_input_i(cmp_in), .current_limit_hiz_pin_i(pin),
      .battery_current_buffer_enable_o(o[0]), .system_power_sense_enable_o(o[1]),
      .low_power_hot_alert_enable_o(o[2]), .input_sense_resistor_select_o(o[3]),
      .charge_sense_resistor_select_o(o[4]), .system_power_gain_select_o(o[5]),
      .comparator_reference_select_o(o[6]), .comparator_output_o(o[7]),
      .converter_disable_o(o[8]), .charger_ok_output_o(o[9]),
      .pass_through_mode_o(o[10]), .high_impedance_mode_o(o[11]),
      .shipping_discharge_o(o[12]), .wakeup_charge_o(o[13]));
   // 40 MHz clock
   initial begin
      core_clk_i = 1'b0;
      forever #12.5 core_clk_i = ~core_clk_i;
   end
   // hang guard, well above the roughly four hundred cycles the tests take
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles > 5000) begin
         errors++;
         stop_test;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk_i);
   endtask
   task automatic stop_test;
      $display("compares=%0d errors=%0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic t_reset;
      host.rd(COBK_ADDR_HIGH, d);
      chk(d, COBK_RESET_HIGH);
      host.rd(COBK_ADDR_LOW, d);
      chk(d, COBK_RESET_LOW);
      host.rd(8'h32, d);
      chk(d, COBK_UNMAPPED);
      chk({o[13:8], o[5], o[0]}, 8'h0A);
      $display("reset test done");
   endtask
   // adapter absent (charger ok low) while the hot alert is enabled
   task automatic t_high;
      chg_ok = 1'b0;
      host.wr(COBK_ADDR_HIGH, 8'hBF);
      cyc(2);
      chk({2'b00, o[5:0]}, 8'h3F);
      lpm = 1'b1;
      cyc(2);
      chk({2'b00, o[5:0]}, 8'h3C);
      lpm = 1'b0;
      chg_ok = 1'b1;
      host.wr(COBK_ADDR_HIGH, 8'h40);
      host.rd(COBK_ADDR_HIGH, d);
      chk(d, 8'h40);
      chk({2'b00, o[5:0]}, 8'h00);
      pin = 1'b0;
      cyc(6);
      chk({6'h00, o[11:10]}, 8'h02);
      host.wr(COBK_ADDR_HIGH, 8'h01);
      cyc(2);
      chk({6'h00, o[11:10]}, 8'h01);
      pin = 1'b1;
      $display("high byte test done");
   endtask
   task automatic t_low;
      host.wr(COBK_ADDR_LOW, 8'h15);
      cyc(6);
      chk({7'h00, o[10]}, 8'h01);
      host.wr(COBK_ADDR_LOW, 8'h13);
      cyc(2);
      chk({6'h00, o[12], o[10]}, 8'h02);
      cyc(25);
      chk({7'h00, o[12]}, 8'h00);
      host.rd(COBK_ADDR_LOW, d);
      chk(d, 8'h11);
      below = 1'b1;
      cyc(3);
      chk({7'h00, o[13]}, 8'h01);
      below = 1'b0;
      cyc(3);
      host.rd(COBK_ADDR_LOW, d);
      chk({o[13], d[6:0]}, 8'h10);
      host.wr(COBK_ADDR_LOW, 8'h11);
      below = 1'b1;
      cyc(60);
      host.rd(COBK_ADDR_LOW, d);
      chk({o[13], d[6:0]}, 8'h11);
      below = 1'b0;
      $display("low byte test done");
   endtask
   task automatic t_cmp;
      host.wr(COBK_ADDR_LOW, 8'h18);
      cmp_in = 1'b1;
      cyc(20);
      chk({7'h00, o[7]}, 8'h01);
      cyc(40);
      chk({5'h00, o[9:7]}, 8'h02);
      cmp_in = 1'b0;
      cyc(8);
      chk({5'h00, o[9:7]}, 8'h03);
      host.wr(COBK_ADDR_LOW, 8'h20);
      cyc(3);
      chk({6'h00, o[9:8]}, 8'h02);
      cmp_in = 1'b1;
      cyc(50);
      chk({7'h00, o[7]}, 8'h01);
      cyc(30);
      chk({7'h00, o[7]}, 8'h00);
      host.wr(COBK_ADDR_LOW, 8'h60);
      cyc(8);
      chk({7'h00, o[7]}, 8'h01);
      host.wr(COBK_ADDR_LOW, 8'h80);
      cmp_in = 1'b0;
      cyc(8);
      chk({6'h00, o[7:6]}, 8'h03);
      // longest deglitch code: output holds high until its own count runs out
      host.wr(COBK_ADDR_LOW, 8'h30);
      cmp_in = 1'b1;
      cyc(70);
      chk({7'h00, o[7]}, 8'h01);
      cyc(20);
      chk({7'h00, o[7]}, 8'h00);
      $display("comparator test done");
   endtask
   // reset for four cycles, then the tests in turn
   initial begin
      {rstn_i, lpm, below, cmp_in} = 4'h0;
      {chg_ok, pin} = 2'b11;
      errors = 0;
      compares = 0;
      cycles = 0;
      cyc(4);
      rstn_i = 1'b1;
      cyc(6);
      t_reset;
      t_high;
      t_low;
      t_cmp;
      stop_test;
   end
endmodule // tb_charger_option_control_bank
`default_nettype wire
